// *** dv/i2m_master_bench.sv ***
/*
  Self-checking bench for the two-wire master transmitter.
  Assumes the slave model on the lines, pull-ups on both lines.
*/
`timescale 1ns/1ps
`default_nettype none
`include "i2m_regs.svh"
module i2m_master_bench;
  import i2m_pkg::*;
  typedef struct packed {
    logic [2:0] rate;
    logic [7:0] reload;
    logic refuse;
    logic [11:0] div;
    logic [7:0] code;
  } i2m_row_t;
  logic core_clk, rstn, bus_irq_enable, bus_irq, data_space, refuse;
  logic master_tx_or_rx, s_oe, rival;
  logic [7:0] timer_one_reload, sfr_rdata, last_byte, n_stops, v, s0;
  i2m_sfr_req_t sfr_req;
  i2m_pins_t pins_oe;
  wire scl = !pins_oe.scl_oe; // open drain with pull-up
  wire sda = !(pins_oe.sda_oe || s_oe || rival); // rival: another master
  int mismatches, n_compared, n;
  i2m_row_t rows [8];
  logic [11:0] divs [8] = '{`I2M_DIV0, `I2M_DIV1, `I2M_DIV2, `I2M_DIV3,
    `I2M_DIV4, `I2M_DIV5, `I2M_DIV6, (`I2M_T1_SPAN - 12'd254) * `I2M_T1_MUL};
  // ==========================================================
  // design and far side
  i2m_master i2m_master_inst (.core_clk(core_clk), .rstn(rstn),
    .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .bus_irq_enable(bus_irq_enable), .timer_one_reload(timer_one_reload),
    .bus_irq(bus_irq), .data_space(data_space),
    .master_tx_or_rx(master_tx_or_rx), .clock_line_pin_in(scl),
    .data_line_pin_in(sda), .pins_oe(pins_oe), .clock_line_pin_out(),
    .data_line_pin_out());
  i2m_slave_model i2m_slave_model_inst (.core_clk(core_clk), .rstn(rstn),
    .scl(scl), .sda(sda), .refuse(refuse), .sda_oe(s_oe),
    .last_byte(last_byte), .n_stops(n_stops));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = !core_clk;
  end
  // ==========================================================
  // register port cycles, driven at the falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    sfr_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge core_clk);
    sfr_req = '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    sfr_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge core_clk);
    sfr_req = '0;
    d = sfr_rdata; // registered answer has landed
  endtask : rd
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test();
    $display("mismatches %0d compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test
  function automatic logic [7:0] ctl(input logic [2:0] r,
      input logic sa, input logic so);
    return {r[2], 1'b1, sa, so, 1'b0, 1'b0, r[1:0]}; // flag written 0
  endfunction : ctl
  // poll the flag before the status read
  task automatic wait_si(input logic [7:0] exp);
    logic [7:0] c;
    c = 8'h00;
    for (int k = 0; k < 3000 && c[3] !== 1'b1; k++) rd(`I2M_CTRL_ADDR, c);
    if (c[3] !== 1'b1) begin
      mismatches++;
      $display("[ERR] %0t flag never rose", $time);
      stop_test();
    end
    rd(`I2M_STATUS_ADDR, c);
    chk(c, exp);
  endtask : wait_si
  // clock cycles between the second and third rising edges of scl
  task automatic period(output int p);
    int rises;
    logic q;
    rises = 0;
    p = 0;
    q = scl;
    for (int k = 0; k < 4000 && rises < 3; k++) begin
      @(negedge core_clk);
      if (rises == 2) p++;
      if (scl && !q) rises++;
      q = scl;
    end
    if (rises < 3) begin
      mismatches++;
      $display("[ERR] %0t no clock on the line", $time);
      stop_test();
    end
  endtask : period
  task automatic stop_bus(input logic [2:0] r, input logic sa);
    s0 = n_stops;
    wr(`I2M_CTRL_ADDR, ctl(r, sa, 1'b1));
    for (int k = 0; k < 3000 && n_stops == s0; k++) @(negedge core_clk);
    chk(n_stops, s0 + 8'h01);
    if (n_stops == s0) stop_test();
    repeat (4) @(negedge core_clk);
    rd(`I2M_CTRL_ADDR, v);
    chk(v[4], 1'b0);
  endtask : stop_bus
  // ==========================================================
  // main sequence
  initial begin
    sfr_req = '0;
    {bus_irq_enable, refuse, rstn, rival} = 4'b0000;
    timer_one_reload = 8'h00;
    for (int i = 0; i < 8; i++) begin
      rows[i] = '{i[2:0], (i == 7) ? 8'hfe : 8'h00, i[0], divs[i],
        i[0] ? `I2M_CODE_AW_NACK : `I2M_CODE_AW_ACK};
    end
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    rstn = 1'b1;
    rd(`I2M_STATUS_ADDR, v);
    chk(v, `I2M_CODE_IDLE);
    wr(`I2M_STATUS_ADDR, 8'h00);
    rd(`I2M_STATUS_ADDR, v);
    chk(v, `I2M_CODE_IDLE);
    chk(bus_irq, 1'b0);
    // every rate code, acked and refused addresses
    for (int i = 0; i < 8; i++) begin
      timer_one_reload = rows[i].reload;
      refuse = rows[i].refuse;
      wr(`I2M_CTRL_ADDR, ctl(rows[i].rate, 1'b1, 1'b0));
      wait_si(`I2M_CODE_START);
      wr(`I2M_DATA_ADDR, {4'ha, i[2:0], 1'b0});
      wr(`I2M_CTRL_ADDR, ctl(rows[i].rate, 1'b0, 1'b0));
      period(n);
      chk((n >= rows[i].div && n <= rows[i].div + 2), 1'b1);
      wait_si(rows[i].code);
      chk(last_byte, {4'ha, i[2:0], 1'b0});
      stop_bus(rows[i].rate, 1'b0);
      rd(`I2M_STATUS_ADDR, v);
      chk(v, `I2M_CODE_IDLE);
    end
    // stretched bus, interrupt gating, full queue drained
    refuse = 1'b0;
    timer_one_reload = 8'h00;
    wr(`I2M_CTRL_ADDR, ctl(3'h0, 1'b1, 1'b0));
    wait_si(`I2M_CODE_START);
    wr(`I2M_DATA_ADDR, 8'h50);
    wr(`I2M_CTRL_ADDR, ctl(3'h0, 1'b0, 1'b0));
    wait_si(`I2M_CODE_AW_ACK);
    repeat (3) @(negedge core_clk);
    chk(bus_irq, 1'b0);
    bus_irq_enable = 1'b1;
    repeat (3) @(negedge core_clk);
    chk(bus_irq, 1'b1);
    for (int k = 0; k < 17; k++) wr(`I2M_DATA_ADDR, 8'h30 + k[7:0]);
    chk(data_space, 1'b0); // full queue refuses
    chk(scl, 1'b0);
    rd(`I2M_STATUS_ADDR, v);
    chk(v, `I2M_CODE_AW_ACK);
    for (int k = 0; k < 16; k++) begin
      wr(`I2M_CTRL_ADDR, ctl(3'h0, 1'b0, 1'b0));
      wait_si(`I2M_CODE_D_ACK);
      chk(last_byte, 8'h30 + k[7:0]);
    end
    chk(data_space, 1'b1); // drained
    refuse = 1'b1;
    wr(`I2M_DATA_ADDR, 8'h7e);
    wr(`I2M_CTRL_ADDR, ctl(3'h0, 1'b0, 1'b0));
    wait_si(`I2M_CODE_D_NACK);
    wr(`I2M_CTRL_ADDR, ctl(3'h0, 1'b1, 1'b0));
    wait_si(`I2M_CODE_RSTART);
    refuse = 1'b0;
    wr(`I2M_DATA_ADDR, 8'ha1);
    wr(`I2M_CTRL_ADDR, ctl(3'h0, 1'b0, 1'b0));
    wait_si(`I2M_CODE_AW_ACK);
    chk(master_tx_or_rx, 1'b1);
    stop_bus(3'h0, 1'b1);
    wait_si(`I2M_CODE_START);
    // a stop is only a legal answer once the address has gone out
    wr(`I2M_DATA_ADDR, 8'ha0);
    wr(`I2M_CTRL_ADDR, ctl(3'h0, 1'b0, 1'b0));
    wait_si(`I2M_CODE_AW_ACK);
    stop_bus(3'h0, 1'b0);
    chk(master_tx_or_rx, 1'b0);
    // a rival pulls data low under a sent one: lost, then drop or retry
    for (int j = 0; j < 2; j++) begin
      wr(`I2M_CTRL_ADDR, ctl(3'h0, 1'b1, 1'b0));
      wait_si(`I2M_CODE_START);
      wr(`I2M_DATA_ADDR, 8'ha0);
      rival = 1'b1;
      wr(`I2M_CTRL_ADDR, ctl(3'h0, j[0], 1'b0));
      wait_si(`I2M_CODE_LOST);
      rival = 1'b0;
      wr(`I2M_CTRL_ADDR, ctl(3'h0, j[0], 1'b0));
      repeat (2) @(negedge core_clk);
      chk(pins_oe, 2'b00);
    end
    wait_si(`I2M_CODE_START);
    chk(bus_irq, 1'b1);
    // reset in mid frame drops flag, pins and interrupt
    rstn = 1'b0;
    @(negedge core_clk);
    chk({bus_irq, pins_oe}, 3'b000);
    rstn = 1'b1;
    rd(`I2M_STATUS_ADDR, v);
    chk(v, `I2M_CODE_IDLE);
    chk(data_space, 1'b1); // queue empty again
    stop_test();
  end
endmodule : i2m_master_bench
`default_nettype wire

// *** dv/i2m_slave_model.sv ***
/*
  Behavioural two-wire slave: logs each byte, acks or refuses it.
  Assumes resolved open-drain lines with pull-ups, one core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module i2m_slave_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // resolved lines and ack choice
  input wire logic scl,
  input wire logic sda,
  input wire logic refuse,
  // data line pull-down and byte log
  output logic sda_oe,
  output logic [7:0] last_byte,
  output logic [7:0] n_stops
);
  logic [3:0] bits; // bit slot within a byte, 9 = ack slot
  logic [7:0] shreg; // bits gathered so far
  logic scl_q; // line levels one cycle ago
  logic sda_q;
  // ==========================================================
  // framing; never stretches, so the master sets the pace
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      {bits, shreg, sda_oe, last_byte, n_stops} <= '0;
      {scl_q, sda_q} <= 2'b11;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (scl && scl_q && sda_q && !sda) begin
        bits <= 4'h0; // start or repeated start
      end else if (scl && scl_q && !sda_q && sda) begin
        bits <= 4'h0; // stop
        n_stops <= n_stops + 8'h01;
      end else if (scl && !scl_q) begin
        if (bits < 4'h8) begin
          shreg <= {shreg[6:0], sda}; // msb first
          bits <= bits + 4'h1;
        end else begin
          bits <= 4'h9;
        end
      end else if (!scl && scl_q) begin
        if (bits == 4'h8) begin
          last_byte <= shreg;
          sda_oe <= !refuse; // low line is an ack
        end else if (bits == 4'h9) begin
          sda_oe <= 1'b0; // release after ack slot
          bits <= 4'h0;
        end
      end
    end
  end
endmodule : i2m_slave_model
`default_nettype wire

// *** rtl/i2m_fifo.sv ***
/*
  Byte queue between firmware data writes and the serial engine.
  Assumes the drain side pops only while out_valid is high.
*/
`timescale 1ns/1ps
`default_nettype none
module i2m_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic fresh; // head just written, read data not yet caught up
  } i2m_fq_t;
  i2m_fq_t q, next_q;
  logic push, pop;
  logic [AW-1:0] rd_next;
  // ==========================================================
  // pointer and count update
  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_q = q;
    rd_next = pop ? AW'(q.rp + 1'b1) : q.rp;
    if (push) begin
      next_q.wp = AW'(q.wp + 1'b1);
    end
    next_q.rp = rd_next;
    next_q.cnt = (AW+1)'(q.cnt + push - pop);
    next_q.fresh = push && (q.wp == rd_next); // stale head hazard
  end
  assign in_ready = (q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (q.cnt > (AW+1)'(1)) ||
                     ((q.cnt == (AW+1)'(1)) && !q.fresh);
  // ==========================================================
  // state register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
  i2m_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_mem (
    .core_clk(core_clk),
    .we(push),
    .waddr(q.wp),
    .wdata(in_data),
    .raddr(rd_next),
    .rdata(out_data)
  );
endmodule : i2m_fifo
`default_nettype wire

// *** rtl/i2m_master.sv ***
/*
  Two-wire bus master transmitter with status code register.
  Assumes the processor reaches registers over a special function
  register port, and open-drain pins are resolved outside.
*/
`timescale 1ns/1ps
`default_nettype none
`include "i2m_regs.svh"
module i2m_master (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // register port
  input wire i2m_pkg::i2m_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  // system side
  input wire logic bus_irq_enable,
  input wire logic [7:0] timer_one_reload,
  output logic bus_irq,
  output logic data_space,
  output logic master_tx_or_rx,
  // open-drain pins
  input wire logic clock_line_pin_in,
  input wire logic data_line_pin_in,
  output i2m_pkg::i2m_pins_t pins_oe,
  output logic clock_line_pin_out,
  output logic data_line_pin_out
);
  import i2m_pkg::*;

  typedef struct packed {
    i2m_phase_t phase;
    logic [1:0] sub; // step inside start or stop
    logic [11:0] div_cnt; // half-period counter
    logic [2:0] bit_cnt;
    logic [7:0] shift;
    logic en;
    logic start_request;
    logic stop_request;
    logic si;
    logic aa;
    logic [2:0] rate;
    logic [7:0] code; // pending state code
    logic [7:0] status; // visible status register
    logic rep; // next start is a repeated one
    logic was_addr; // last byte was an address
    logic lost;
    logic rx_mode;
    i2m_pins_t oe;
    logic irq;
    logic space;
    logic [7:0] rdata;
  } i2m_state_t;

  i2m_state_t s, next_s;
  logic tick; // one half bit period elapsed
  logic fifo_in_ready, fifo_out_valid, fifo_pop, data_wr;
  logic [7:0] fifo_out_data;
  logic [11:0] half;
  logic ctrl_wr, si_clear;

  // ==========================================================
  // rate divisor from code and timer reload
  function automatic logic [11:0] rate_div(input logic [2:0] sel,
                                           input logic [7:0] rl);
    case (sel)
      3'h0: rate_div = `I2M_DIV0;
      3'h1: rate_div = `I2M_DIV1;
      3'h2: rate_div = `I2M_DIV2;
      3'h3: rate_div = `I2M_DIV3;
      3'h4: rate_div = `I2M_DIV4;
      3'h5: rate_div = `I2M_DIV5;
      3'h6: rate_div = `I2M_DIV6;
      default: rate_div = 12'((`I2M_T1_SPAN - {4'h0, rl}) * `I2M_T1_MUL);
    endcase
  endfunction : rate_div

  // ==========================================================
  // byte queue for addresses and data
  assign data_wr = sfr_req.wr && (sfr_req.addr == `I2M_DATA_ADDR);
  i2m_fifo #(.WIDTH(8), .DEPTH(`I2M_FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .rstn(rstn),
    .in_valid(data_wr),
    .in_ready(fifo_in_ready),
    .in_data(sfr_req.wdata),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  // ==========================================================
  // next state
  always_comb begin
    next_s = s;
    fifo_pop = 1'b0;
    ctrl_wr = sfr_req.wr && (sfr_req.addr == `I2M_CTRL_ADDR);
    si_clear = ctrl_wr && !sfr_req.wdata[`I2M_SI_BIT];
    // half period, never under one cycle
    half = rate_div(s.rate, timer_one_reload) >> 1;
    tick = (s.div_cnt == 12'h0);
    next_s.div_cnt = tick ? 12'(half - 12'h1) : 12'(s.div_cnt - 12'h1);
    // firmware clear of the flag; engine sets below win
    if (si_clear) begin
      next_s.si = 1'b0;
    end
    case (s.phase)
      I2M_IDLE: begin
        next_s.div_cnt = 12'h0;
        next_s.oe = '0;
        if (s.en && s.start_request && !s.si && clock_line_pin_in &&
            data_line_pin_in) begin
          next_s.phase = I2M_START;
          next_s.sub = 2'h0;
          next_s.rep = 1'b0;
        end
      end
      I2M_WAIT_FREE: begin
        next_s.oe = '0;
        // bus free once both lines sit high for a half period
        if (!(clock_line_pin_in && data_line_pin_in)) begin
          next_s.div_cnt = 12'(half - 12'h1);
        end else if (tick) begin
          next_s.phase = I2M_START;
          next_s.sub = 2'h0;
          next_s.rep = 1'b0;
        end
      end
      I2M_START: begin
        if (tick) begin
          next_s.sub = 2'(s.sub + 2'h1);
          case (s.sub)
            2'h0: next_s.oe.sda_oe = 1'b0; // release data first
            2'h1: next_s.oe.scl_oe = 1'b0;
            2'h2: next_s.oe.sda_oe = 1'b1; // data falls, clock high
            default: begin
              next_s.oe.scl_oe = 1'b1;
              next_s.code = s.rep ? `I2M_CODE_RSTART
                                  : `I2M_CODE_START;
              next_s.si = 1'b1;
              next_s.phase = I2M_HOLD;
            end
          endcase
        end
      end
      I2M_BIT_LO: begin
        // data settles early in the low phase, never with the clock edge
        next_s.oe.sda_oe = !s.shift[7];
        if (tick) begin
          next_s.oe.scl_oe = 1'b0;
          next_s.phase = I2M_BIT_HI;
        end
      end
      I2M_BIT_HI: begin
        // a slave stretching the clock pauses the count
        if (!clock_line_pin_in) begin
          next_s.div_cnt = s.div_cnt;
        end else if (tick) begin
          if (s.shift[7] && !data_line_pin_in) begin
            // someone else won the line: let go at once
            next_s.oe = '0;
            next_s.lost = 1'b1;
            next_s.code = `I2M_CODE_LOST;
            next_s.si = 1'b1;
            next_s.phase = I2M_HOLD;
          end else begin
            next_s.oe.scl_oe = 1'b1;
            next_s.shift = {s.shift[6:0], 1'b0};
            next_s.bit_cnt = 3'(s.bit_cnt + 3'h1);
            next_s.phase = (s.bit_cnt == 3'h7) ? I2M_ACK_LO : I2M_BIT_LO;
          end
        end
      end
      I2M_ACK_LO: begin
        next_s.oe.sda_oe = 1'b0; // release data early for the ack bit
        if (tick) begin
          next_s.oe.scl_oe = 1'b0;
          next_s.phase = I2M_ACK_HI;
        end
      end
      I2M_ACK_HI: begin
        if (!clock_line_pin_in) begin
          next_s.div_cnt = s.div_cnt;
        end else if (tick) begin
          next_s.oe.scl_oe = 1'b1;
          if (s.was_addr) begin
            next_s.code = data_line_pin_in ? `I2M_CODE_AW_NACK
                                           : `I2M_CODE_AW_ACK;
          end else begin
            next_s.code = data_line_pin_in ? `I2M_CODE_D_NACK
                                           : `I2M_CODE_D_ACK;
          end
          next_s.si = 1'b1;
          next_s.phase = I2M_HOLD;
        end
      end
      I2M_HOLD: begin
        next_s.div_cnt = 12'(half - 12'h1);
        // clock stays pulled low while the flag stands, except after lost arbitration
        next_s.oe.scl_oe = !s.lost;
        if (s.si) begin
          next_s.phase = I2M_HOLD; // nothing moves until cleared
        end else if (s.lost) begin
          next_s.lost = 1'b0;
          next_s.oe = '0;
          next_s.phase = s.start_request ? I2M_WAIT_FREE : I2M_IDLE;
        end else if ((s.code == `I2M_CODE_START) ||
                     (s.code == `I2M_CODE_RSTART)) begin
          // address byte; empty queue stalls with clock held low
          if (fifo_out_valid) begin
            fifo_pop = 1'b1;
            next_s.shift = fifo_out_data;
            next_s.bit_cnt = 3'h0;
            next_s.was_addr = 1'b1;
            next_s.rx_mode = fifo_out_data[0];
            next_s.phase = I2M_BIT_LO;
          end
        end else if (s.stop_request) begin
          next_s.phase = I2M_STOP;
          next_s.sub = 2'h0;
        end else if (s.start_request) begin
          next_s.phase = I2M_START;
          next_s.sub = 2'h0;
          next_s.rep = 1'b1;
        end else if (fifo_out_valid) begin
          fifo_pop = 1'b1;
          next_s.shift = fifo_out_data;
          next_s.bit_cnt = 3'h0;
          next_s.was_addr = 1'b0;
          next_s.phase = I2M_BIT_LO;
        end
      end
      I2M_STOP: begin
        if (tick) begin
          next_s.sub = 2'(s.sub + 2'h1);
          case (s.sub)
            2'h0: next_s.oe.sda_oe = 1'b1; // data low under low clock
            2'h1: next_s.oe.scl_oe = 1'b0;
            default: begin
              next_s.oe.sda_oe = 1'b0; // data rises: stop on the bus
              next_s.stop_request = 1'b0;
              next_s.rx_mode = 1'b0;
              next_s.sub = 2'h0;
              next_s.rep = 1'b0;
              next_s.phase = s.start_request ? I2M_START : I2M_IDLE;
            end
          endcase
        end
      end
      default: begin
        next_s.phase = I2M_IDLE;
        next_s.oe = '0;
      end
    endcase
    // firmware control write; flag bit only clears, never sets
    if (ctrl_wr) begin
      next_s.en = sfr_req.wdata[`I2M_EN_BIT];
      next_s.start_request = sfr_req.wdata[`I2M_STA_BIT];
      next_s.aa = sfr_req.wdata[`I2M_AA_BIT];
      next_s.rate = {sfr_req.wdata[`I2M_CR2_BIT],
                     sfr_req.wdata[`I2M_CR1_BIT],
                     sfr_req.wdata[`I2M_CR0_BIT]};
      if (sfr_req.wdata[`I2M_STO_BIT]) begin
        next_s.stop_request = 1'b1;
      end
    end
    // five code bits over three zero bits
    next_s.status = s.si ? {s.code[7:3], 3'h0}
                         : `I2M_CODE_IDLE;
    next_s.irq = s.si && bus_irq_enable;
    next_s.space = fifo_in_ready;
    if (sfr_req.rd) begin
      case (sfr_req.addr)
        `I2M_CTRL_ADDR: next_s.rdata = {s.rate[2], s.en, s.start_request, s.stop_request,
                                        s.si, s.aa, s.rate[1:0]};
        `I2M_STATUS_ADDR: next_s.rdata = s.status;
        default: next_s.rdata = 8'h0;
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
      s.phase <= I2M_IDLE;
      s.code <= `I2M_CODE_IDLE;
      s.status <= `I2M_CODE_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // outputs, all from the state register
  assign sfr_rdata = s.rdata;
  assign bus_irq = s.irq;
  assign data_space = s.space;
  assign master_tx_or_rx = s.rx_mode;
  assign pins_oe = s.oe;
  assign clock_line_pin_out = s.rdata[7] & 1'b0; // open drain drives low
  assign data_line_pin_out = s.rdata[7] & 1'b0;

  // ==========================================================
  // checks
  sequence stop_done_s;
    (s.phase == I2M_STOP) && tick && (s.sub == 2'h2);
  endsequence
  sequence flag_rise_s;
    !s.si ##1 s.si;
  endsequence
  rate_fast_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (s.phase == I2M_BIT_LO && tick && s.rate == 3'h0)
    |=> (s.div_cnt == 12'd4))
    else $error("half period wrong for code zero");
  status_low_a: assert property (@(posedge core_clk) disable iff (!rstn)
    s.status[2:0] == 3'h0)
    else $error("status low bits not zero");
  idle_quiet_a: assert property (@(posedge core_clk) disable iff (!rstn)
    s.si |-> (s.code != `I2M_CODE_IDLE))
    else $error("flag set with idle code");
  status_follow_a: assert property (@(posedge core_clk) disable iff (!rstn)
    flag_rise_s |=> (s.status == $past(s.code)))
    else $error("status did not follow flag by one cycle");
  status_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (s.si && $past(s.si)) |=> $stable(s.status))
    else $error("status changed while flag set");
  stop_clear_a: assert property (@(posedge core_clk) disable iff (!rstn)
    stop_done_s |=> (!s.stop_request || $past(ctrl_wr)))
    else $error("stop flag not cleared after stop");
  stop_start_a: assert property (@(posedge core_clk) disable iff (!rstn)
    stop_done_s ##0 s.start_request |=> (s.phase == I2M_START))
    else $error("no start after stop");
  stretch_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (s.phase == I2M_HOLD && s.si && !s.lost) |=> s.oe.scl_oe)
    else $error("clock not held low under flag");
  irq_gate_a: assert property (@(posedge core_clk) disable iff (!rstn)
    s.irq |-> ($past(s.si) && $past(bus_irq_enable)))
    else $error("interrupt without flag and enable");
  lost_free_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (s.phase == I2M_HOLD && s.lost && !s.si && !s.start_request)
    |=> (s.phase == I2M_IDLE) && !s.oe.scl_oe)
    else $error("bus not released after lost arbitration");
endmodule : i2m_master
`default_nettype wire

// *** rtl/i2m_mem.sv ***
/*
  Small dual-port memory with registered read data.
  Assumes one clock; read returns the word stored before this edge.
*/
`timescale 1ns/1ps
`default_nettype none
module i2m_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
) (
  // clock
  input wire logic core_clk,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // read port
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] cells [DEPTH]; // storage, no reset needed
  // ==========================================================
  // write and registered read
  always_ff @(posedge core_clk) begin
    if (we) begin
      cells[waddr] <= wdata;
    end
    rdata <= cells[raddr];
  end
endmodule : i2m_mem
`default_nettype wire

// *** rtl/i2m_pkg.sv ***
/*
  Types shared by the two-wire master engine and its bench.
  Assumes the includer compiles this before any module.
*/
package i2m_pkg;
  // ==========================================================
  // engine phases, gray along start, bits, ack, hold, stop
  typedef enum logic [3:0] {
    I2M_IDLE = 4'h0,
    I2M_START = 4'h1,
    I2M_BIT_LO = 4'h3,
    I2M_BIT_HI = 4'h2,
    I2M_ACK_LO = 4'h6,
    I2M_ACK_HI = 4'h7,
    I2M_HOLD = 4'h5,
    I2M_STOP = 4'h4,
    I2M_WAIT_FREE = 4'hc
  } i2m_phase_t;
  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } i2m_sfr_req_t;
  // open-drain pin drive pair
  typedef struct packed {
    logic scl_oe;
    logic sda_oe;
  } i2m_pins_t;
endpackage : i2m_pkg

// *** rtl/i2m_regs.svh ***
/*
  Register offsets, control bit positions, status codes and rate divisors
  for the two-wire master transmitter engine.
  Assumes the includer sits on the special function register port.
*/
`ifndef I2M_REGS_SVH
`define I2M_REGS_SVH
// ==========================================================
// special function register offsets
`define I2M_CTRL_ADDR 8'hd8
`define I2M_STATUS_ADDR 8'hd9
`define I2M_DATA_ADDR 8'hda
// ==========================================================
// control register bit positions
`define I2M_CR2_BIT 7
`define I2M_EN_BIT 6
`define I2M_STA_BIT 5
`define I2M_STO_BIT 4
`define I2M_SI_BIT 3
`define I2M_AA_BIT 2
`define I2M_CR1_BIT 1
`define I2M_CR0_BIT 0
// ==========================================================
// status codes and reset value
`define I2M_CODE_IDLE 8'hf8
`define I2M_CODE_START 8'h08
`define I2M_CODE_RSTART 8'h10
`define I2M_CODE_AW_ACK 8'h18
`define I2M_CODE_AW_NACK 8'h20
`define I2M_CODE_D_ACK 8'h28
`define I2M_CODE_D_NACK 8'h30
`define I2M_CODE_LOST 8'h38
// ==========================================================
// clock division factors per rate code
`define I2M_DIV0 12'd10
`define I2M_DIV1 12'd20
`define I2M_DIV2 12'd30
`define I2M_DIV3 12'd40
`define I2M_DIV4 12'd80
`define I2M_DIV5 12'd120
`define I2M_DIV6 12'd160
`define I2M_T1_SPAN 12'd256
`define I2M_T1_MUL 12'd12
`define I2M_FIFO_DEPTH 16
`endif
